/* verilog/prts_pkg.sv */
// What this block does
// - in normal mode, trigger write latches every port's frame start
// - port-0 read returns last trigger frame start
// - trigger stamps visible only after frame ends; armed ports update at their frame start
// - port-1 register holds port-1 frame start
// - port-2 register holds port-2 frame start
// - port-3 register holds port-3 frame start
// - simple mode latches port 0, arms others
// - armed port takes first frame, then disarms
// - four words mapped from 0x0900 upward
package prts_pkg;

    localparam int NUM_PORTS = 4;
    localparam int TIME_W    = 64;
    localparam int STAMP_W   = 32;
    localparam int ADDR_W    = 16;

    localparam logic [ADDR_W-1:0] PORT0_RX_TIME_OFS = 16'h0900;
    localparam logic [ADDR_W-1:0] PORT1_RX_TIME_OFS = 16'h0904;
    localparam logic [ADDR_W-1:0] PORT2_RX_TIME_OFS = 16'h0908;
    localparam logic [ADDR_W-1:0] PORT3_RX_TIME_OFS = 16'h090c;

    // word index sits in address bits 3:2, block select above them
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 3;
    localparam int SEL_LSB = 4;

    localparam logic [STAMP_W-1:0] RD_DATA_RST = 32'h0000_0000;

    localparam logic [2:0] CMD_NONE                  = 3'h0;
    localparam logic [2:0] CMD_BROADCAST_WRITE       = 3'h1;
    localparam logic [2:0] CMD_AUTO_INC_PHYS_WRITE   = 3'h2;
    localparam logic [2:0] CMD_CONFIGURED_ADDR_WRITE = 3'h3;
    localparam logic [2:0] CMD_OTHER                 = 3'h7;

    typedef enum logic {
        ST_IDLE,
        ST_PENDING
    } prts_trig_state_t;

    // any byte of the four receive-time words
    function automatic logic prts_addr_hit(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SEL_LSB] == PORT0_RX_TIME_OFS[ADDR_W-1:SEL_LSB];
    endfunction

    // any byte of the port-0 word
    function automatic logic prts_port0_hit(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:IDX_LSB] == PORT0_RX_TIME_OFS[ADDR_W-1:IDX_LSB];
    endfunction

endpackage

/* verilog/prts_port_stamp.sv */
`timescale 1ns/1ps
module prts_port_stamp
    import prts_pkg::*;
#(
    parameter int TW     = TIME_W,
    parameter int SW     = STAMP_W,
    parameter bit IS_REF = 1'b0
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic [TW-1:0] i_local_time,
    input  wire logic          i_sof,
    input  wire logic          i_simple_mode,
    input  wire logic          i_commit,
    input  wire logic          i_arm,
    output logic      [SW-1:0] o_stamp,
    output logic               o_armed
);

    logic [SW-1:0] frame_start_q;
    logic [SW-1:0] stamp_q;
    logic          armed_q;
    logic          armed_d;
    wire  logic [SW-1:0] now_stamp   = i_local_time[SW-1:0];
    wire  logic          take_commit = i_commit & (~i_simple_mode | IS_REF);
    wire  logic          take_armed  = armed_q & i_sof & i_simple_mode
                                       & ~IS_REF;

    // stamps carry no reset: undefined until the first capture
    always_ff @(posedge i_sys_clk) begin
        if (i_sof) begin
            frame_start_q <= now_stamp;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (take_commit) begin
            stamp_q <= frame_start_q;
        end else if (take_armed) begin
            stamp_q <= now_stamp;
        end
    end

    // arming wins over the capture that would disarm
    assign armed_d = (i_arm & ~IS_REF) ? 1'b1
                   : (take_armed ? 1'b0 : armed_q);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
        end
    end

    assign o_stamp = stamp_q;
    assign o_armed = armed_q;

    a_commit_copy: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        take_commit && !i_sof |=> stamp_q == $past(frame_start_q))
        else $error("commit did not copy the frame start");

    a_armed_once: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        take_armed && !i_arm && !take_commit
        |=> stamp_q == $past(now_stamp) && !armed_q)
        else $error("armed capture wrong or port stayed armed");

endmodule // prts_port_stamp

/* verilog/prts_read_port.sv */
`timescale 1ns/1ps
module prts_read_port
    import prts_pkg::*;
#(
    parameter int N  = NUM_PORTS,
    parameter int SW = STAMP_W
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_rd_stb,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    input  wire logic [SW-1:0]     i_stamps [N],
    output logic      [SW-1:0]     o_rd_data,
    output logic                   o_rd_valid,
    output logic                   o_rd_hit
);

    logic [SW-1:0] rd_data_q;
    logic          rd_valid_q;
    logic          rd_hit_q;
    wire  logic    hit = prts_addr_hit(i_rd_addr);
    wire  logic [1:0] idx = i_rd_addr[IDX_MSB:IDX_LSB];
    // whole word returned; the bus picks its byte lanes
    wire  logic [SW-1:0] sel_data = hit ? i_stamps[idx] : RD_DATA_RST;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_q  <= RD_DATA_RST;
            rd_valid_q <= 1'b0;
            rd_hit_q   <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_stb;
            rd_hit_q   <= i_rd_stb & hit;
            if (i_rd_stb) begin
                rd_data_q <= sel_data;
            end
        end
    end

    assign o_rd_data  = rd_data_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_hit   = rd_hit_q;

    a_read_word: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_rd_stb && hit |=> o_rd_valid && o_rd_hit
            && o_rd_data == $past(i_stamps[idx]))
        else $error("read returned the wrong receive time");

    a_read_miss: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_rd_stb && !hit |=> o_rd_valid && !o_rd_hit
            && o_rd_data == RD_DATA_RST)
        else $error("unmapped read not answered with zero");

endmodule // prts_read_port

/* verilog/prts_top.sv */
`timescale 1ns/1ps
module prts_top
    import prts_pkg::*;
#(
    parameter int N  = NUM_PORTS,
    parameter int TW = TIME_W,
    parameter int SW = STAMP_W
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset_n,
    input  wire logic [TW-1:0]     i_local_time,
    input  wire logic [N-1:0]      i_sof,
    input  wire logic              i_frame_end,
    input  wire logic              i_frame_ok,
    input  wire logic              i_simple_mode,
    input  wire logic              i_net_wr_stb,
    input  wire logic [2:0]        i_net_wr_cmd,
    input  wire logic [ADDR_W-1:0] i_net_wr_addr,
    input  wire logic              i_net_rd_stb,
    input  wire logic [ADDR_W-1:0] i_net_rd_addr,
    input  wire logic              i_pdi_rd_stb,
    input  wire logic [ADDR_W-1:0] i_pdi_rd_addr,
    input  wire logic              i_pdi_wr_stb,
    input  wire logic [ADDR_W-1:0] i_pdi_wr_addr,
    output logic      [SW-1:0]     o_net_rd_data,
    output logic                   o_net_rd_valid,
    output logic                   o_net_rd_hit,
    output logic      [SW-1:0]     o_pdi_rd_data,
    output logic                   o_pdi_rd_valid,
    output logic                   o_pdi_rd_hit,
    output logic                   o_pdi_wr_denied,
    output logic                   o_trig_pending,
    output logic      [N-1:0]      o_armed
);

    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // trigger decode: the three physical/broadcast write kinds only
    wire logic cmd_is_trig = (i_net_wr_cmd == CMD_BROADCAST_WRITE)
                           | (i_net_wr_cmd == CMD_AUTO_INC_PHYS_WRITE)
                           | (i_net_wr_cmd == CMD_CONFIGURED_ADDR_WRITE);
    wire logic trig = i_net_wr_stb & cmd_is_trig
                    & prts_port0_hit(i_net_wr_addr);

    prts_trig_state_t state_q;
    prts_trig_state_t state_d;
    logic             commit_q;
    logic             arm_q;
    logic             pdi_denied_q;
    logic             pend_q;

    wire logic pending = (state_q == ST_PENDING);
    // a trigger seen in the frame's last cycle still counts for that frame
    wire logic commit_d = i_frame_end & i_frame_ok
                        & (pending | trig);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (trig && !i_frame_end) begin
                    state_d = ST_PENDING;
                end
            end
            ST_PENDING: begin
                if (i_frame_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q      <= ST_IDLE;
            commit_q     <= 1'b0;
            arm_q        <= 1'b0;
            pdi_denied_q <= 1'b0;
            pend_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            pend_q       <= state_d == ST_PENDING;
            commit_q     <= commit_d;
            arm_q        <= trig & i_simple_mode;
            // interface writes never reach the stamps
            pdi_denied_q <= i_pdi_wr_stb
                          & prts_addr_hit(i_pdi_wr_addr);
        end
    end

    logic [SW-1:0] stamps [N];
    logic [N-1:0]  armed;

    // port 0 is the reference in simple mode, never armed
    for (genvar g = 0; g < N; g++) begin : g_port
        prts_port_stamp #(
            .TW     (TW),
            .SW     (SW),
            .IS_REF (g == 0)
        ) u_stamp (
            .i_sys_clk     (i_sys_clk),
            .i_rst_n       (rst_n_q),
            .i_local_time  (i_local_time),
            .i_sof         (i_sof[g]),
            .i_simple_mode (i_simple_mode),
            .i_commit      (commit_q),
            .i_arm         (arm_q),
            .o_stamp       (stamps[g]),
            .o_armed       (armed[g])
        );
    end

    prts_read_port #(
        .N  (N),
        .SW (SW)
    ) u_net_rd (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (rst_n_q),
        .i_rd_stb   (i_net_rd_stb),
        .i_rd_addr  (i_net_rd_addr),
        .i_stamps   (stamps),
        .o_rd_data  (o_net_rd_data),
        .o_rd_valid (o_net_rd_valid),
        .o_rd_hit   (o_net_rd_hit)
    );

    prts_read_port #(
        .N  (N),
        .SW (SW)
    ) u_pdi_rd (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (rst_n_q),
        .i_rd_stb   (i_pdi_rd_stb),
        .i_rd_addr  (i_pdi_rd_addr),
        .i_stamps   (stamps),
        .o_rd_data  (o_pdi_rd_data),
        .o_rd_valid (o_pdi_rd_valid),
        .o_rd_hit   (o_pdi_rd_hit)
    );

    assign o_pdi_wr_denied = pdi_denied_q;
    assign o_trig_pending  = pend_q;
    assign o_armed         = armed;

    a_trig_pends: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        trig && !i_frame_end |=> o_trig_pending)
        else $error("trigger write did not pend");

    a_commit_at_end: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        o_trig_pending && i_frame_end && i_frame_ok
        |=> commit_q && !o_trig_pending)
        else $error("pending capture not committed at frame end");

    a_commit_cause: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        commit_q |-> $past(i_frame_end) && $past(i_frame_ok))
        else $error("commit outside a good frame end");

    a_stamp_quiet: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        !commit_q ##1 1'b1 |-> $stable(stamps[0]))
        else $error("port 0 stamp moved without a commit");

    a_simple_arm: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        trig && i_simple_mode |-> ##2 &armed[N-1:1] && !armed[0])
        else $error("simple mode trigger did not arm ports");

    a_pdi_denied: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        i_pdi_wr_stb && prts_addr_hit(i_pdi_wr_addr)
        |=> o_pdi_wr_denied && $stable(stamps[0]))
        else $error("interface write not refused");

    // assertion helpers: each port's last start time, kept apart from the
    // stamp units so that a broken copy path cannot hide behind itself
    logic [SW-1:0] chk_sof_q [N];
    logic [N-1:0]  chk_seen_q;

    always_ff @(posedge i_sys_clk) begin
        for (int p = 0; p < N; p++) begin
            if (i_sof[p]) begin
                chk_sof_q[p] <= i_local_time[SW-1:0];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chk_seen_q <= '0;
        end else begin
            chk_seen_q <= chk_seen_q | i_sof;
        end
    end

    // a trigger in a good frame's last cycle commits at once, never pends
    a_last_trig: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        trig && i_frame_end && i_frame_ok && !pending
        |=> commit_q && !o_trig_pending)
        else $error("last-cycle trigger not committed");

    a_pend_holds: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        o_trig_pending && !i_frame_end |=> o_trig_pending)
        else $error("pending capture lost inside the frame");

    a_pend_clears: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        i_frame_end |=> !o_trig_pending)
        else $error("pending capture outlived its frame");

    a_bad_frame: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        i_frame_end && !i_frame_ok |=> !commit_q)
        else $error("capture committed for a bad frame");

    a_idle_quiet: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        !o_trig_pending && !trig |=> !commit_q)
        else $error("capture committed without a trigger");

    a_other_cmd: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        i_net_wr_stb && !cmd_is_trig && !o_trig_pending
        |=> !o_trig_pending)
        else $error("non-trigger command started a capture");

    a_upper_words: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        i_net_wr_stb && !prts_port0_hit(i_net_wr_addr) && !o_trig_pending
        |=> !o_trig_pending)
        else $error("write outside port-0 word started a capture");

    a_ref_unarmed: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        !o_armed[0])
        else $error("reference port was armed");

    a_normal_no_arm: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        trig && !i_simple_mode |=> !arm_q)
        else $error("trigger armed ports outside simple mode");

    a_denied_only: assert property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        !(i_pdi_wr_stb && prts_addr_hit(i_pdi_wr_addr))
        |=> !o_pdi_wr_denied)
        else $error("refusal flagged without an interface write");

    // ports that never saw a start pulse keep an undefined stamp
    for (genvar g = 0; g < N; g++) begin : g_stamp_chk
        a_stamp_normal: assert property (@(posedge i_sys_clk)
            disable iff (!rst_n_q)
            commit_q && !i_simple_mode && chk_seen_q[g]
            |=> stamps[g] == $past(chk_sof_q[g]))
            else $error("port stamp differs from its frame start");
    end

    for (genvar g = 1; g < N; g++) begin : g_arm_chk
        a_armed_hold: assert property (@(posedge i_sys_clk)
            disable iff (!rst_n_q)
            o_armed[g] && !i_sof[g] |=> o_armed[g])
            else $error("armed port disarmed without a frame");

        a_armed_stamp: assert property (@(posedge i_sys_clk)
            disable iff (!rst_n_q)
            o_armed[g] && i_sof[g] && i_simple_mode
            |=> stamps[g] == $past(i_local_time[SW-1:0]))
            else $error("armed port took the wrong time");

        a_armed_clear: assert property (@(posedge i_sys_clk)
            disable iff (!rst_n_q)
            o_armed[g] && i_sof[g] && i_simple_mode && !arm_q
            |=> !o_armed[g])
            else $error("armed port stayed armed after its frame");
    end

    c_commit: cover property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        trig ##[1:50] commit_q);

    c_armed_take: cover property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        armed[1] ##1 !armed[1]);

    c_read_hit: cover property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        commit_q ##[1:20] o_pdi_rd_hit);

    c_bad_frame: cover property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        o_trig_pending && i_frame_end && !i_frame_ok);

    c_all_armed: cover property (@(posedge i_sys_clk)
        disable iff (!rst_n_q)
        &armed[N-1:1]);

endmodule // prts_top

/* sim/prts_net_master.sv */
`timescale 1ns/1ps
module prts_net_master
    import prts_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic [TIME_W-1:0]    i_local_time,
    output logic      [NUM_PORTS-1:0] o_sof,
    output logic                      o_wr_stb,
    output logic      [2:0]           o_wr_cmd,
    output logic      [ADDR_W-1:0]    o_wr_addr,
    output logic                      o_frame_end,
    output logic                      o_frame_ok
);
    logic [STAMP_W-1:0] sof_time [NUM_PORTS];

    initial begin
        o_sof       = '0;
        o_wr_stb    = 1'b0;
        o_wr_cmd    = CMD_NONE;
        o_wr_addr   = '0;
        o_frame_end = 1'b0;
        o_frame_ok  = 1'b0;
    end

    // preamble at each port in turn, then the optional write of the frame
    task automatic start(input logic [2:0] cmd, input logic [ADDR_W-1:0] a,
                         input logic wr);
        for (int p = 0; p < NUM_PORTS; p++) begin
            @(negedge i_sys_clk);
            o_sof       = NUM_PORTS'(1) << p;
            sof_time[p] = i_local_time[STAMP_W-1:0];
        end
        @(negedge i_sys_clk);
        o_sof     = '0;
        o_wr_stb  = wr;
        o_wr_cmd  = cmd;
        o_wr_addr = a;
        @(negedge i_sys_clk);
        o_wr_stb  = 1'b0;
        // released lines show the inverse so a stale value never matches
        o_wr_cmd  = ~cmd;
        o_wr_addr = ~a;
    endtask

    task automatic stop(input logic ok);
        @(negedge i_sys_clk);
        o_frame_end = 1'b1;
        o_frame_ok  = ok;
        @(negedge i_sys_clk);
        o_frame_end = 1'b0;
        o_frame_ok  = ~ok;
    endtask
endmodule // prts_net_master

/* sim/port_receive_time_stamping_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("Error %s expected %h seen %h", n, e, g); end end
module port_receive_time_stamping_test;
    import prts_pkg::*;
    logic                 clk, rst_n, fend, fok, smode, wstb;
    logic [TIME_W-1:0]    ltime;
    logic [NUM_PORTS-1:0] sof, armed;
    logic [2:0]           wcmd;
    logic [ADDR_W-1:0]    waddr, nra, pra, pwa;
    logic                 nrs, prs, pws, nrv, nrh, prv, prh, denied, pend;
    logic [STAMP_W-1:0]   nrd, prd;
    logic [STAMP_W-1:0]   exp_t [NUM_PORTS];
    int                   error_cnt, total_checks;

    prts_top uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_local_time(ltime),
        .i_sof(sof), .i_frame_end(fend), .i_frame_ok(fok),
        .i_simple_mode(smode), .i_net_wr_stb(wstb), .i_net_wr_cmd(wcmd),
        .i_net_wr_addr(waddr), .i_net_rd_stb(nrs), .i_net_rd_addr(nra),
        .i_pdi_rd_stb(prs), .i_pdi_rd_addr(pra), .i_pdi_wr_stb(pws),
        .i_pdi_wr_addr(pwa), .o_net_rd_data(nrd), .o_net_rd_valid(nrv),
        .o_net_rd_hit(nrh), .o_pdi_rd_data(prd), .o_pdi_rd_valid(prv),
        .o_pdi_rd_hit(prh), .o_pdi_wr_denied(denied),
        .o_trig_pending(pend), .o_armed(armed));

    prts_net_master net (.i_sys_clk(clk), .i_local_time(ltime),
        .o_sof(sof), .o_wr_stb(wstb), .o_wr_cmd(wcmd), .o_wr_addr(waddr),
        .o_frame_end(fend), .o_frame_ok(fok));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) ltime <= ltime + 64'h1;

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // low address bits are ignored, so any byte of the word is used
    function automatic logic [ADDR_W-1:0] word_addr(input int p);
        return PORT0_RX_TIME_OFS + ADDR_W'(4 * p + $urandom_range(3));
    endfunction

    // same address on both read ports; the answer stands one cycle
    task automatic rd(input logic [ADDR_W-1:0] a, input logic hit,
                      input logic [STAMP_W-1:0] d);
        nrs = 1'b1;
        prs = 1'b1;
        nra = a;
        pra = a;
        @(negedge clk);
        nrs = 1'b0;
        prs = 1'b0;
        nra = ~a;
        pra = ~a;
        `CHK("net_rd", {1'b1, hit, d}, {nrv, nrh, nrd})
        `CHK("pdi_rd", {1'b1, hit, d}, {prv, prh, prd})
        @(negedge clk);
    endtask

    task automatic rd_all();
        for (int p = 0; p < NUM_PORTS; p++) rd(word_addr(p), 1'b1, exp_t[p]);
    endtask

    initial begin
        error_cnt = 0;
        total_checks = 0;
        void'($urandom(50017));
        ltime = {$urandom(), $urandom()};
        {rst_n, smode, nrs, prs, pws} = '0;
        {nra, pra, pwa} = '0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("pending", 1'b0, pend)
        for (int i = 0; i < 6; i++) begin
            net.start(3'(1 + i % 3), word_addr(0), 1'b1);
            `CHK("pending", 1'b1, pend)
            if (i > 0) rd(word_addr(1), 1'b1, exp_t[1]);
            net.stop(1'b1);
            // stamps land two edges after the frame end
            if (i > 0) rd(word_addr(0), 1'b1, exp_t[0]);
            else @(negedge clk);
            `CHK("pending", 1'b0, pend)
            for (int p = 0; p < NUM_PORTS; p++) exp_t[p] = net.sof_time[p];
            rd_all();
            repeat ($urandom_range(4)) @(negedge clk);
        end
        net.start(CMD_OTHER, word_addr(0), 1'b1);
        `CHK("pending", 1'b0, pend)
        net.stop(1'b1);
        net.start(CMD_BROADCAST_WRITE, word_addr(2), 1'b1);
        `CHK("pending", 1'b0, pend)
        net.stop(1'b1);
        net.start(CMD_CONFIGURED_ADDR_WRITE, word_addr(0), 1'b1);
        net.stop(1'b0);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            pws = 1'($urandom_range(1)) | (i == 0);
            pwa = (i < 4) ? word_addr(i) : 16'h0910;
            @(negedge clk);
            `CHK("wr_denied", pws & (i < 4), denied)
            pws = 1'b0;
        end
        `CHK("pending", 1'b0, pend)
        repeat (2) @(negedge clk);
        rd_all();
        rd(16'h0910 + 16'($urandom_range(16'h06ef)), 1'b0,
           RD_DATA_RST);
        smode = ~smode;
        net.start(CMD_AUTO_INC_PHYS_WRITE, word_addr(0), 1'b1);
        net.stop(1'b1);
        repeat (2) @(negedge clk);
        exp_t[0] = net.sof_time[0];
        `CHK("armed", 4'he, armed)
        rd_all();
        net.start(CMD_NONE, '0, 1'b0);
        for (int p = 1; p < NUM_PORTS; p++) exp_t[p] = net.sof_time[p];
        `CHK("armed", 4'h0, armed)
        rd_all();
        net.stop(1'b1);
        net.start(CMD_NONE, '0, 1'b0);
        net.stop(1'b1);
        repeat (2) @(negedge clk);
        rd_all();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule // port_receive_time_stamping_test
